// file: bdc_defs.vh
`ifndef BDC_DEFS_VH
`define BDC_DEFS_VH

// Command codes of the readable data words
`define BDC_CMD_CHG_TIME 8'h05
`define BDC_CMD_DSG_TIME 8'h06
`define BDC_CMD_RATE_OK 8'h07
`define BDC_CMD_TEMP 8'h08
`define BDC_CMD_VOLT 8'h09
`define BDC_CMD_CURR 8'h0A
`define BDC_CMD_AVG_CURR 8'h0B
`define BDC_CMD_MARGIN 8'h0C
`define BDC_CMD_PCT_LRN 8'h0D
`define BDC_CMD_PCT_DES 8'h0E
`define BDC_CMD_CAP_LEFT 8'h0F

// Status error codes
`define BDC_ERR_OK 3'h0
`define BDC_ERR_BUSY 3'h1
`define BDC_ERR_UNSUPPORTED 3'h3

// Data limits and markers
`define BDC_TIME_INVALID 16'hFFFF
`define BDC_TIME_MAX 16'hFFFE
`define BDC_WORD_MAX 16'hFFFF
`define BDC_TEMP_MIN 16'h0964
`define BDC_TEMP_MAX 16'h0F28
`define BDC_VOLT_MAX 16'h4E20
`define BDC_PCT_FULL 16'h0064
`define BDC_BOOL_TRUE 16'h0001
`define BDC_BOOL_FALSE 16'h0000

// Error margin values in percent and the tally count per margin step
`define BDC_MARGIN_RESET 7'h64
`define BDC_MARGIN_LEARNED 7'h02
`define BDC_MARGIN_CLAMPED 7'h08
`define BDC_MARGIN_VCORR 7'h19
`define BDC_MARGIN_MAX 7'h64
`define BDC_CYCLES_PER_STEP 2'h3

// Scale factors and divider width
`define BDC_MIN_PER_HOUR 32'h0000003C
`define BDC_PCT_SCALE 32'h00000064
`define BDC_OK_SCALE 32'h00000168
`define BDC_DIV_BITS 6'h20

// Timing
`define BDC_CLK_HZ 100000000
`define BDC_REFRESH_S 20
`define BDC_RECALC_LIMIT_MS 1300

`endif

// file: bdc_bank.v
// Summary of operation
// - After an at-rate write, all three prediction results are recomputed well within 1.3 s.
// - Reading a prediction result before recomputation ends is not acknowledged; error becomes busy.
// - Prediction results are recomputed from the stored at-rate value every 20 s.
// - Charge time in minutes up to 65534; 65535 when at-rate is not charging.
// - Discharge time in minutes; 65535 when at-rate is not discharging.
// - Rate-OK is boolean and forced true for zero or positive at-rate.
// - Negative at-rate: rate-OK tells if capacity covers that added load plus the present discharge current for 10 s.
// - Temperature word in 0.1 K, held within 240.4 to 388.0 K.
// - Voltage word in millivolts, held within 0 to 20000.
// - Current word is signed milliamps, positive charging, negative discharging.
// - Average current approximates a one-minute rolling mean, valid from the first sample.
// - Full reset loads the error margin with 100 percent.
// - Unclamped completed learning cycle sets the error margin to 2 percent.
// - Clamped learning cycle sets margin to 8 percent unless already below 8.
// - Four cycle-tally advances without learning raise the margin by 1 percent.
// - A voltage-based counter correction sets the error margin to 25 percent.
// - Error margin stays within 2 to 100 percent.
// - Relative charge is remaining over learned full capacity, 0 to 100 percent.
// - Absolute charge is remaining over nominal capacity, not clamped at 100.
// - Remaining capacity word 0 to 65535, mAh or 10 mWh by unit selector.
// - Unit selector set picks 10 mW/10 mWh, clear picks mA/mAh.
// - At-rate is signed: positive charge, negative discharge, zero neither (default).
`timescale 1ns/100ps
`default_nettype none
`include "bdc_defs.vh"

module bdc_bank #(
  parameter [31:0] REFRESH_CYCLES = `BDC_REFRESH_S * `BDC_CLK_HZ,
  parameter AVG_SHIFT = 6
) (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Word read request from the bus protocol engine
  input wire rd_req,
  input wire [7:0] rd_cmd,
  output reg rd_ack,
  output reg rd_nack,
  output reg [15:0] rd_data,
  output reg [2:0] status_err_code,
  // At-rate hypothesis write
  input wire rate_wr,
  input wire [15:0] rate_wdata,
  // Unit selector from the pack mode word
  input wire capacity_mode,
  // Measurements
  input wire meas_valid,
  input wire [15:0] meas_temp,
  input wire [15:0] meas_volt,
  input wire [15:0] meas_curr,
  // Capacity figures in both units
  input wire [15:0] cap_left_mah,
  input wire [15:0] cap_left_cwh,
  input wire [15:0] learned_full_mah,
  input wire [15:0] learned_full_cwh,
  input wire [15:0] nominal_mah,
  input wire [15:0] nominal_cwh,
  // Learning and correction events
  input wire learn_done,
  input wire learn_clamped,
  input wire cycle_tally_inc,
  input wire volt_correction
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_DIV = 2'h2;
  localparam [1:0] ST_STORE = 2'h3;
  localparam [1:0] JOB_FULL = 2'h0;
  localparam [1:0] JOB_EMPTY = 2'h1;
  localparam [1:0] JOB_REL = 2'h2;
  localparam [1:0] JOB_ABS = 2'h3;

  // Saturate a wide quotient to a 16-bit ceiling
  function [15:0] sat16;
    input [31:0] val;
    input [15:0] ceil;
    begin
      if (val > {16'h0000, ceil}) begin
        sat16 = ceil;
      end else begin
        sat16 = val[15:0];
      end
    end
  endfunction

  // Magnitude of a signed word
  function [15:0] mag16;
    input [15:0] val;
    begin
      if (val[15]) begin
        mag16 = ~val + 16'h0001;
      end else begin
        mag16 = val;
      end
    end
  endfunction

  reg [15:0] rate_r;
  reg busy_r;
  reg start_req_r;
  reg [31:0] tick_cnt_r;
  reg [1:0] state_r;
  reg [1:0] job_r;
  reg [5:0] bit_cnt_r;
  reg [31:0] num_r;
  reg [15:0] den_r;
  reg [16:0] rem_r;
  reg [15:0] chg_time_r;
  reg [15:0] dsg_time_r;
  reg rate_ok_r;
  reg [15:0] pct_lrn_r;
  reg [15:0] pct_des_r;
  reg [15:0] temp_r;
  reg [15:0] volt_r;
  reg [15:0] curr_r;
  reg [15:0] avg_r;
  reg avg_seeded_r;
  reg [6:0] margin_r;
  reg [1:0] cyc_cnt_r;

  // Unit selection for capacity figures and the hypothesis
  wire [15:0] cap_left = capacity_mode ? cap_left_cwh : cap_left_mah;
  wire [15:0] full_cap = capacity_mode ? learned_full_cwh : learned_full_mah;
  wire [15:0] nom_cap = capacity_mode ? nominal_cwh : nominal_mah;
  wire rate_pos = ~rate_r[15] && (rate_r != 16'h0000);
  wire rate_neg = rate_r[15];
  wire [15:0] rate_mag = mag16(rate_r);
  wire [15:0] to_fill = (full_cap > cap_left) ? (full_cap - cap_left) : 16'h0000;

  // Ten-second load test: left * 3600 s/h / 10 s against added plus present drain
  wire [31:0] ok_supply = {16'h0000, cap_left} * `BDC_OK_SCALE;
  wire [15:0] drain = curr_r[15] ? mag16(curr_r) : 16'h0000;
  wire [31:0] ok_demand = {16'h0000, rate_mag} + {16'h0000, drain};
  wire ok_calc = ~rate_neg || (ok_supply >= ok_demand);

  // Divider step
  wire [16:0] rem_sh = {rem_r[15:0], num_r[31]};
  wire q_bit = (rem_sh >= {1'b0, den_r});
  wire [16:0] rem_nxt = q_bit ? (rem_sh - {1'b0, den_r}) : rem_sh;
  wire [31:0] quo = {num_r[30:0], q_bit};
  wire tick = (tick_cnt_r == REFRESH_CYCLES - 32'h00000001);

  // Refresh timer for the periodic prediction update
  always @(posedge core_clk) begin
    if (!rstn) begin
      tick_cnt_r <= 32'h00000000;
    end else if (tick) begin
      tick_cnt_r <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end
  end

  // Hypothesis storage, pending request and not-ready flag
  always @(posedge core_clk) begin
    if (!rstn) begin
      rate_r <= 16'h0000;
      busy_r <= 1'b0;
      start_req_r <= 1'b0;
    end else begin
      if (rate_wr) begin
        rate_r <= rate_wdata;
      end
      // A new request wins over the clear taken at the start of a round
      if (rate_wr || tick || meas_valid) begin
        start_req_r <= 1'b1;
      end else if (state_r == ST_IDLE) begin
        start_req_r <= 1'b0;
      end
      if (rate_wr) begin
        busy_r <= 1'b1;
      end else if (state_r == ST_STORE && job_r == JOB_ABS && !start_req_r) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Sequential divider walking the four quotient jobs; about 140 cycles per round
  always @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      job_r <= JOB_FULL;
      bit_cnt_r <= 6'h00;
      num_r <= 32'h00000000;
      den_r <= 16'h0000;
      rem_r <= 17'h00000;
      chg_time_r <= `BDC_TIME_INVALID;
      dsg_time_r <= `BDC_TIME_INVALID;
      rate_ok_r <= 1'b1;
      pct_lrn_r <= 16'h0000;
      pct_des_r <= 16'h0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_req_r) begin
            job_r <= JOB_FULL;
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          rem_r <= 17'h00000;
          bit_cnt_r <= `BDC_DIV_BITS;
          state_r <= ST_DIV;
          case (job_r)
            JOB_FULL: begin
              num_r <= {16'h0000, to_fill} * `BDC_MIN_PER_HOUR;
              den_r <= rate_mag;
            end
            JOB_EMPTY: begin
              num_r <= {16'h0000, cap_left} * `BDC_MIN_PER_HOUR;
              den_r <= rate_mag;
            end
            JOB_REL: begin
              num_r <= {16'h0000, cap_left} * `BDC_PCT_SCALE;
              den_r <= full_cap;
            end
            default: begin
              num_r <= {16'h0000, cap_left} * `BDC_PCT_SCALE;
              den_r <= nom_cap;
            end
          endcase
        end
        ST_DIV: begin
          rem_r <= rem_nxt;
          num_r <= quo;
          bit_cnt_r <= bit_cnt_r - 6'h01;
          if (bit_cnt_r == 6'h01) begin
            state_r <= ST_STORE;
          end
        end
        ST_STORE: begin
          // Words change only here and otherwise hold their last value
          case (job_r)
            JOB_FULL: begin
              chg_time_r <= rate_pos ? sat16(num_r, `BDC_TIME_MAX) : `BDC_TIME_INVALID;
            end
            JOB_EMPTY: begin
              dsg_time_r <= rate_neg ? sat16(num_r, `BDC_TIME_MAX) : `BDC_TIME_INVALID;
            end
            JOB_REL: begin
              pct_lrn_r <= (full_cap == 16'h0000) ? 16'h0000 :
                           sat16(num_r, `BDC_PCT_FULL);
            end
            default: begin
              pct_des_r <= (nom_cap == 16'h0000) ? 16'h0000 :
                           sat16(num_r, `BDC_WORD_MAX);
              rate_ok_r <= ok_calc;
            end
          endcase
          if (job_r == JOB_ABS) begin
            state_r <= ST_IDLE;
          end else begin
            job_r <= job_r + 2'h1;
            state_r <= ST_LOAD;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Exponential filter step; AVG_SHIFT sets the window against the sample rate
  wire signed [16:0] avg_diff = $signed({meas_curr[15], meas_curr}) - $signed({avg_r[15], avg_r});
  wire signed [16:0] avg_sh = avg_diff >>> AVG_SHIFT;
  wire [15:0] avg_step = avg_sh[15:0];

  // Measurement words latched on each sample; temperature and voltage range-held
  always @(posedge core_clk) begin
    if (!rstn) begin
      temp_r <= `BDC_TEMP_MIN;
      volt_r <= 16'h0000;
      curr_r <= 16'h0000;
      avg_r <= 16'h0000;
      avg_seeded_r <= 1'b0;
    end else if (meas_valid) begin
      if (meas_temp < `BDC_TEMP_MIN) begin
        temp_r <= `BDC_TEMP_MIN;
      end else if (meas_temp > `BDC_TEMP_MAX) begin
        temp_r <= `BDC_TEMP_MAX;
      end else begin
        temp_r <= meas_temp;
      end
      volt_r <= (meas_volt > `BDC_VOLT_MAX) ? `BDC_VOLT_MAX : meas_volt;
      curr_r <= meas_curr;
      // First sample seeds the filter so early reads are meaningful
      if (!avg_seeded_r) begin
        avg_r <= meas_curr;
        avg_seeded_r <= 1'b1;
      end else begin
        avg_r <= avg_r + avg_step;
      end
    end
  end

  // Error margin bookkeeping
  always @(posedge core_clk) begin
    if (!rstn) begin
      margin_r <= `BDC_MARGIN_RESET;
      cyc_cnt_r <= 2'h0;
    end else if (volt_correction) begin
      margin_r <= `BDC_MARGIN_VCORR;
    end else if (learn_done) begin
      cyc_cnt_r <= 2'h0;
      if (!learn_clamped) begin
        margin_r <= `BDC_MARGIN_LEARNED;
      end else if (margin_r >= `BDC_MARGIN_CLAMPED) begin
        margin_r <= `BDC_MARGIN_CLAMPED;
      end
    end else if (cycle_tally_inc) begin
      if (cyc_cnt_r == `BDC_CYCLES_PER_STEP) begin
        cyc_cnt_r <= 2'h0;
        if (margin_r < `BDC_MARGIN_MAX) begin
          margin_r <= margin_r + 7'h01;
        end
      end else begin
        cyc_cnt_r <= cyc_cnt_r + 2'h1;
      end
    end
  end

  // Read answer one cycle after the request
  always @(posedge core_clk) begin
    if (!rstn) begin
      rd_ack <= 1'b0;
      rd_nack <= 1'b0;
      rd_data <= 16'h0000;
      status_err_code <= `BDC_ERR_OK;
    end else begin
      rd_ack <= 1'b0;
      rd_nack <= 1'b0;
      if (rd_req) begin
        rd_ack <= 1'b1;
        status_err_code <= `BDC_ERR_OK;
        case (rd_cmd)
          `BDC_CMD_CHG_TIME, `BDC_CMD_DSG_TIME, `BDC_CMD_RATE_OK: begin
            if (busy_r) begin
              rd_ack <= 1'b0;
              rd_nack <= 1'b1;
              status_err_code <= `BDC_ERR_BUSY;
            end else if (rd_cmd == `BDC_CMD_CHG_TIME) begin
              rd_data <= chg_time_r;
            end else if (rd_cmd == `BDC_CMD_DSG_TIME) begin
              rd_data <= dsg_time_r;
            end else begin
              rd_data <= rate_ok_r ? `BDC_BOOL_TRUE : `BDC_BOOL_FALSE;
            end
          end
          `BDC_CMD_TEMP: rd_data <= temp_r;
          `BDC_CMD_VOLT: rd_data <= volt_r;
          `BDC_CMD_CURR: rd_data <= curr_r;
          `BDC_CMD_AVG_CURR: rd_data <= avg_r;
          `BDC_CMD_MARGIN: rd_data <= {9'h000, margin_r};
          `BDC_CMD_PCT_LRN: rd_data <= pct_lrn_r;
          `BDC_CMD_PCT_DES: rd_data <= pct_des_r;
          `BDC_CMD_CAP_LEFT: rd_data <= cap_left;
          default: begin
            rd_ack <= 1'b0;
            rd_nack <= 1'b1;
            status_err_code <= `BDC_ERR_UNSUPPORTED;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: bdc_bank_chk.sv
`timescale 1ns/100ps
`default_nettype none
module bdc_bank_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Read channel and at-rate strobe
  input wire logic rd_req,
  input wire logic [7:0] rd_cmd,
  input wire logic rd_ack,
  input wire logic rd_nack,
  input wire logic [15:0] rd_data,
  input wire logic [2:0] status_err_code,
  input wire logic rate_wr,
  input wire logic volt_correction
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Exactly one answer per request, and none without one
  property p_answer; rd_req |=> rd_ack != rd_nack; endproperty
  a_answer: assert property (p_answer) else $error("read not answered once");
  property p_no_stray; (rd_ack || rd_nack) |-> $past(rd_req); endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without request");
  property p_bad_cmd;
    rd_req && (rd_cmd < 8'h05 || rd_cmd > 8'h0F) |=> rd_nack && status_err_code == 3'h3;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command not refused");
  // Prediction reads within a few cycles of an at-rate write are refused as not ready
  property p_busy;
    rate_wr ##[1:8] (rd_req && rd_cmd >= 8'h05 && rd_cmd <= 8'h07)
      |=> rd_nack && status_err_code == 3'h1;
  endproperty
  a_busy: assert property (p_busy) else $error("early prediction read acknowledged");
  property p_plain;
    rd_req && rd_cmd >= 8'h08 && rd_cmd <= 8'h0F |=> rd_ack && status_err_code == 3'h0;
  endproperty
  a_plain: assert property (p_plain) else $error("data word refused");
  // Range limits of the returned words, and the margin read after a voltage correction
  property p_temp;
    rd_req && rd_cmd == 8'h08 |=> rd_data >= 16'h0964 && rd_data <= 16'h0F28;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature out of range");
  property p_volt; rd_req && rd_cmd == 8'h09 |=> rd_data <= 16'h4E20; endproperty
  a_volt: assert property (p_volt) else $error("voltage out of range");
  property p_margin;
    rd_req && rd_cmd == 8'h0C |=> rd_data >= 16'h0002 && rd_data <= 16'h0064;
  endproperty
  a_margin: assert property (p_margin) else $error("margin out of range");
  property p_rel; rd_req && rd_cmd == 8'h0D |=> rd_data <= 16'h0064; endproperty
  a_rel: assert property (p_rel) else $error("relative charge above full");
  property p_ok_bool;
    rd_req && rd_cmd == 8'h07 |=> rd_nack || rd_data <= 16'h0001;
  endproperty
  a_ok_bool: assert property (p_ok_bool) else $error("rate ok not boolean");
  property p_vcorr;
    volt_correction ##2 (rd_req && rd_cmd == 8'h0C) |=> rd_data == 16'h0019;
  endproperty
  a_vcorr: assert property (p_vcorr) else $error("correction margin wrong");
  // Returned word only moves on a read
  property p_hold; !rd_req |=> $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule
bind bdc_bank bdc_bank_chk i_chk (.core_clk(core_clk), .rstn(rstn), .rd_req(rd_req),
  .rd_cmd(rd_cmd), .rd_ack(rd_ack), .rd_nack(rd_nack), .rd_data(rd_data),
  .status_err_code(status_err_code), .rate_wr(rate_wr), .volt_correction(volt_correction));
`default_nettype wire

// file: bdc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module bdc_host_model (
  // Clock
  input wire logic core_clk,
  // Read channel
  output logic rd_req,
  output logic [7:0] rd_cmd,
  input wire logic rd_ack,
  input wire logic rd_nack,
  input wire logic [15:0] rd_data,
  input wire logic [2:0] status_err_code,
  // At-rate write
  output logic rate_wr,
  output logic [15:0] rate_wdata
);
  // Idle at time zero
  initial begin
    rd_req = 1'b0;
    rd_cmd = 8'h00;
    rate_wr = 1'b0;
    rate_wdata = 16'h0000;
  end
  // Word read; released codes are inverted so a stale command never looks valid
  task automatic read_word(input logic [7:0] cmd, output logic ok, output logic [15:0] d,
      output logic [2:0] e);
    @(negedge core_clk);
    rd_req = 1'b1;
    rd_cmd = cmd;
    @(negedge core_clk);
    rd_req = 1'b0;
    rd_cmd = ~cmd;
    if (rd_ack !== 1'b1 && rd_nack !== 1'b1) @(negedge core_clk);
    ok = rd_ack;
    d = rd_data;
    e = status_err_code;
  endtask
  // Signed at-rate write, one strobe
  task automatic write_rate(input logic [15:0] v);
    @(negedge core_clk);
    rate_wr = 1'b1;
    rate_wdata = v;
    @(negedge core_clk);
    rate_wr = 1'b0;
    rate_wdata = ~v;
  endtask
endmodule
`default_nettype wire

// file: tb_bdc_bank.sv
`timescale 1ns/100ps
`default_nettype none
module tb_bdc_bank;
  logic core_clk, rstn, rd_req, rd_ack, rd_nack, rate_wr, capacity_mode, meas_valid;
  logic [7:0] rd_cmd;
  logic [2:0] status_err_code;
  logic [3:0] ev;
  logic [15:0] rd_data, rate_wdata, meas_temp, meas_volt, meas_curr;
  logic [15:0] cap_left_mah, cap_left_cwh, learned_full_mah, learned_full_cwh;
  logic [15:0] nominal_mah, nominal_cwh;
  int failures = 0;
  int tests_run = 0;

  bdc_bank #(.REFRESH_CYCLES(32'd1000), .AVG_SHIFT(6)) i_dut (.core_clk(core_clk),
    .rstn(rstn), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_ack(rd_ack), .rd_nack(rd_nack),
    .rd_data(rd_data), .status_err_code(status_err_code), .rate_wr(rate_wr),
    .rate_wdata(rate_wdata), .capacity_mode(capacity_mode), .meas_valid(meas_valid),
    .meas_temp(meas_temp), .meas_volt(meas_volt), .meas_curr(meas_curr),
    .cap_left_mah(cap_left_mah), .cap_left_cwh(cap_left_cwh),
    .learned_full_mah(learned_full_mah), .learned_full_cwh(learned_full_cwh),
    .nominal_mah(nominal_mah), .nominal_cwh(nominal_cwh), .learn_done(ev[0]),
    .learn_clamped(ev[1]), .cycle_tally_inc(ev[2]), .volt_correction(ev[3]));

  bdc_host_model i_host (.core_clk(core_clk), .rd_req(rd_req), .rd_cmd(rd_cmd),
    .rd_ack(rd_ack), .rd_nack(rd_nack), .rd_data(rd_data),
    .status_err_code(status_err_code), .rate_wr(rate_wr), .rate_wdata(rate_wdata));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One read; an expected error of zero means the word must be acknowledged
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp, input logic [2:0] xe);
    logic ok;
    logic [15:0] d;
    logic [2:0] e;
    i_host.read_word(cmd, ok, d, e);
    check($sformatf("ack %h", cmd), {15'h0000, ok}, {15'h0000, xe == 3'h0});
    check($sformatf("err %h", cmd), {13'h0000, e}, {13'h0000, xe});
    if (xe == 3'h0) check($sformatf("word %h", cmd), d, exp);
  endtask

  // Measurement strobe, then time for the recompute round
  task automatic sample(input logic [15:0] t, input logic [15:0] v, input logic [15:0] c);
    @(negedge core_clk);
    meas_temp = t;
    meas_volt = v;
    meas_curr = c;
    meas_valid = 1'b1;
    @(negedge core_clk);
    meas_valid = 1'b0;
    repeat (300) @(negedge core_clk);
  endtask

  // Event pulse; the clamp qualifier is a level and drops with it
  task automatic ev_pulse(input logic [3:0] v);
    @(negedge core_clk);
    ev = v;
    @(negedge core_clk);
    ev = 4'h0;
  endtask

  // Write, probe while busy, wait for ready, then read all three results
  task automatic at_rate(input logic [15:0] r, input logic [15:0] tf, input logic [15:0] te,
      input logic [15:0] okx);
    logic ok;
    logic [15:0] d;
    logic [2:0] e;
    int n;
    i_host.write_rate(r);
    @(negedge core_clk);
    rd(8'h05, 16'h0000, 3'h1);
    rd(8'h06, 16'h0000, 3'h1);
    rd(8'h07, 16'h0000, 3'h1);
    n = 0;
    do begin
      i_host.read_word(8'h06, ok, d, e);
      n++;
    end while (ok !== 1'b1 && n < 400);
    check("ready", {15'h0000, ok}, 16'h0001);
    rd(8'h05, tf, 3'h0);
    rd(8'h06, te, 3'h0);
    rd(8'h07, okx, 3'h0);
    $display("test at_rate %h done", r);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    #300000;
    failures++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    ev = 4'h0;
    capacity_mode = 1'b0;
    meas_valid = 1'b0;
    meas_temp = 16'h0BB8;
    meas_volt = 16'h0000;
    meas_curr = 16'h0000;
    cap_left_mah = 16'h01F4;
    cap_left_cwh = 16'h012C;
    learned_full_mah = 16'h03E8;
    learned_full_cwh = 16'h0258;
    nominal_mah = 16'h0190;
    nominal_cwh = 16'h00C8;
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    rd(8'h0C, 16'h0064, 3'h0);
    rd(8'h05, 16'hFFFF, 3'h0);
    rd(8'h06, 16'hFFFF, 3'h0);
    rd(8'h07, 16'h0001, 3'h0);
    rd(8'h04, 16'h0000, 3'h3);
    rd(8'h10, 16'h0000, 3'h3);
    $display("test reset_and_codes done");
    sample(16'h03E8, 16'h7530, 16'hFE0C);
    rd(8'h08, 16'h0964, 3'h0);
    rd(8'h09, 16'h4E20, 3'h0);
    rd(8'h0A, 16'hFE0C, 3'h0);
    rd(8'h0B, 16'hFE0C, 3'h0);
    rd(8'h0D, 16'h0032, 3'h0);
    rd(8'h0E, 16'h007D, 3'h0);
    rd(8'h0F, 16'h01F4, 3'h0);
    capacity_mode = 1'b1;
    sample(16'h1388, 16'h0FA0, 16'hFE0C);
    rd(8'h08, 16'h0F28, 3'h0);
    rd(8'h09, 16'h0FA0, 3'h0);
    rd(8'h0B, 16'hFE0C, 3'h0);
    rd(8'h0E, 16'h0096, 3'h0);
    rd(8'h0F, 16'h012C, 3'h0);
    $display("test measurements done");
    // Four tally steps at the reset value must not push the margin past 100
    repeat (4) ev_pulse(4'h4);
    rd(8'h0C, 16'h0064, 3'h0);
    ev_pulse(4'h1);
    rd(8'h0C, 16'h0002, 3'h0);
    repeat (4) ev_pulse(4'h4);
    rd(8'h0C, 16'h0003, 3'h0);
    ev_pulse(4'h3);
    rd(8'h0C, 16'h0003, 3'h0);
    ev_pulse(4'h8);
    rd(8'h0C, 16'h0019, 3'h0);
    ev_pulse(4'h3);
    rd(8'h0C, 16'h0008, 3'h0);
    $display("test margin done");
    capacity_mode = 1'b0;
    at_rate(16'hFF9C, 16'hFFFF, 16'h012C, 16'h0001);
    cap_left_mah = 16'h0001;
    at_rate(16'hFF9C, 16'hFFFF, 16'h0000, 16'h0000);
    at_rate(16'h0000, 16'hFFFF, 16'hFFFF, 16'h0001);
    at_rate(16'h00C8, 16'h012B, 16'hFFFF, 16'h0001);
    // A changed current moves the filter by one shifted step
    sample(16'h0BB8, 16'h0FA0, 16'h0000);
    rd(8'h08, 16'h0BB8, 3'h0);
    rd(8'h0A, 16'h0000, 3'h0);
    rd(8'h0B, 16'hFE13, 3'h0);
    $display("test average done");
    learned_full_mah = 16'h04B0;
    repeat (1100) @(negedge core_clk);
    rd(8'h05, 16'h0167, 3'h0);
    $display("test refresh done");
    print_verdict();
  end
endmodule
`default_nettype wire
